// [common/fsb_defines.vh]
// constants for the flash synchronous burst read control block
`ifndef FSB_DEFINES_VH
`define FSB_DEFINES_VH

// read configuration word: reset value and writable bits
`define FSB_CFG_RESET 16'hfd4f
`define FSB_CFG_WMASK 16'hfd4f

// field positions inside the read configuration word
`define FSB_RM_BIT 15
`define FSB_LC_MSB 14
`define FSB_LC_LSB 11
`define FSB_WP_BIT 10
`define FSB_WD_BIT 8
`define FSB_BS_BIT 7
`define FSB_CE_BIT 6
`define FSB_BW_BIT 3
`define FSB_BL_MSB 2
`define FSB_BL_LSB 0

// burst size codes
`define FSB_BL_4 3'h1
`define FSB_BL_8 3'h2
`define FSB_BL_16 3'h3
`define FSB_BL_CONT 3'h7

// latency limits and row geometry
`define FSB_LC_MIN 4'h2
`define FSB_ROW_MASK 4'hf
`define FSB_ADDR_MAX 24'hffffff

// reset level of the synchronised control pins {hw_reset_n, out_en_n, chip_sel_n, address_latch_n, burst_clk}
`define FSB_PIN_IDLE 5'h1e

`endif

// [design/fsb_pin_sync.v]
// three-flop pin synchroniser whose output moves once stages two and three agree
`timescale 1ns/10ps
module fsb_pin_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // pin side
  input wire [WIDTH-1:0] pin,
  // synchronised side
  output reg [WIDTH-1:0] value
);

reg [WIDTH-1:0] stage1;
reg [WIDTH-1:0] stage2;
reg [WIDTH-1:0] stage3;

// stage1 feeds only stage2, so no decision is taken on a metastable bit
always @(posedge clk) begin
  if (rst) begin
    stage1 <= RESET_VALUE;
    stage2 <= RESET_VALUE;
    stage3 <= RESET_VALUE;
    value <= RESET_VALUE;
  end else begin
    stage1 <= pin;
    stage2 <= stage1;
    stage3 <= stage2;
    if (stage2 == stage3) begin
      value <= stage3;
    end
  end
end

endmodule

// [design/fsb_read_ctrl.v]
// read-side control of a parallel flash: page or burst reads, latency, row-end stalls, wait pin
//
// What this block does
// - read mode bit one gives asynchronous page reads, zero gives synchronous bursts
// - first burst word appears the programmed number of clock edges after the latch edge
// - unaligned burst start inserts row-end stall at the first sixteen-word boundary
// - latency codes 2 to 15: sixteen words, then up to code minus one stalls
// - wait polarity bit one drives wait active high, zero active low
// - wait only changes on valid clock edges while the bus cycle is active
// - in synchronous mode wait stays asserted until bus data is valid
// - nonarray reads crossing a row end keep correct wait only for the first word
// - asynchronous reads hold wait at its deasserted level
// - wait floats unless chip select and output enable are both low
// - write cycles with output enable high keep wait floating
// - wait early bit set deasserts wait one data cycle ahead of valid data
// - only linear burst order exists; the order bit stays fixed at linear
// - wrap mode bursts of 4, 8, 16 words wrap within the aligned group
// - no-wrap mode and continuous bursts step linearly across group boundaries
// - the clock-edge bit picks the burst clock edge used for data and wait
// - a continuous burst runs to the end of the burstable address space
`timescale 1ns/10ps
`include "fsb_defines.vh"
module fsb_read_ctrl (
  // clock and reset
  input wire clk,
  input wire rst,
  // pins from the memory controller
  input wire burst_clk,
  input wire address_latch_n,
  input wire chip_sel_n,
  input wire out_en_n,
  input wire hw_reset_n,
  input wire [23:0] addr,
  // configuration and nonarray data
  input wire cfg_wr,
  input wire [15:0] cfg_wdata,
  input wire nonarray_sel,
  input wire [15:0] nonarray_word,
  // array load port
  input wire array_wr,
  input wire [7:0] array_wr_addr,
  input wire [15:0] array_wr_data,
  // data and wait pins
  output reg [15:0] dq_out,
  output reg dq_oe,
  output wire wait_out,
  output reg wait_oe,
  // status
  output reg [15:0] read_config_word,
  output wire burst_active
);

localparam ST_IDLE = 3'h0;
localparam ST_LAT = 3'h1;
localparam ST_RUN = 3'h2;
localparam ST_STALL = 3'h3;
localparam ST_DONE = 3'h4;

////////////////////////////////////////////////////////////////////////////////
// functions

// word count of a fixed burst, zero for continuous
function [4:0] fsb_burst_len;
  input [2:0] bl;
  begin
    case (bl)
      `FSB_BL_4: fsb_burst_len = 5'h04;
      `FSB_BL_8: fsb_burst_len = 5'h08;
      `FSB_BL_16: fsb_burst_len = 5'h10;
      default: fsb_burst_len = 5'h00;
    endcase
  end
endfunction

// next burst address: wrap inside the aligned group or step linearly
function [23:0] fsb_next_addr;
  input [23:0] a;
  input [2:0] bl;
  input bw;
  reg [4:0] len;
  reg [3:0] mask;
  reg [3:0] inc;
  begin
    len = fsb_burst_len(bl);
    mask = len[3:0] - 4'h1;
    inc = a[3:0] + 4'h1;
    if (!bw && len != 5'h00) begin
      if (len == 5'h10) begin
        fsb_next_addr = {a[23:4], inc};
      end else begin
        fsb_next_addr = {a[23:4], (inc & mask) | (a[3:0] & ~mask)};
      end
    end else begin
      fsb_next_addr = a + 24'h000001;
    end
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers and burst clock edge

wire [4:0] pins_s;
wire [23:0] addr_s;
wire clk_s = pins_s[0];
wire latch_n_s = pins_s[1];
wire ce_n_s = pins_s[2];
wire oe_n_s = pins_s[3];
wire hw_rst_n_s = pins_s[4];

fsb_pin_sync #(.WIDTH(5), .RESET_VALUE(`FSB_PIN_IDLE)) u_pin_sync (
  .clk(clk),
  .rst(rst),
  .pin({hw_reset_n, out_en_n, chip_sel_n, address_latch_n, burst_clk}),
  .value(pins_s)
);

fsb_pin_sync #(.WIDTH(24), .RESET_VALUE(24'h000000)) u_addr_sync (
  .clk(clk),
  .rst(rst),
  .pin(addr),
  .value(addr_s)
);

reg clk_prev;
always @(posedge clk) begin
  if (rst) begin
    clk_prev <= 1'b0;
  end else begin
    clk_prev <= clk_s;
  end
end

wire rise_edge = clk_s & ~clk_prev;
wire fall_edge = ~clk_s & clk_prev;
wire valid_edge = read_config_word[`FSB_CE_BIT] ? rise_edge : fall_edge;

////////////////////////////////////////////////////////////////////////////////
// configuration

wire sync_mode = ~read_config_word[`FSB_RM_BIT];
wire [3:0] lc_raw = read_config_word[`FSB_LC_MSB:`FSB_LC_LSB];
// codes 0 and 1 are unsupported; they behave as the shortest legal latency
wire [3:0] lc_eff = (lc_raw < `FSB_LC_MIN) ? `FSB_LC_MIN : lc_raw;
wire wait_pol = read_config_word[`FSB_WP_BIT];
wire wait_early = read_config_word[`FSB_WD_BIT];
wire [2:0] bl = read_config_word[`FSB_BL_MSB:`FSB_BL_LSB];
wire no_wrap = read_config_word[`FSB_BW_BIT];
wire bus_active = ~ce_n_s & ~oe_n_s;

// a hardware reset on the pin returns the block to asynchronous defaults
always @(posedge clk) begin
  if (rst || !hw_rst_n_s) begin
    read_config_word <= `FSB_CFG_RESET;
  end else if (cfg_wr) begin
    read_config_word <= cfg_wdata & `FSB_CFG_WMASK;
  end
end

////////////////////////////////////////////////////////////////////////////////
// burst sequencer, stepped on valid burst clock edges

reg [2:0] state;
reg [3:0] lat_cnt;
reg [23:0] seq_addr;
reg [4:0] word_cnt;
reg [3:0] stall_cnt;
reg stalled;
reg seq_valid;
reg [3:0] stall_len;

reg [2:0] next_state;
reg [3:0] next_lat_cnt;
reg [23:0] next_seq_addr;
reg [4:0] next_word_cnt;
reg [3:0] next_stall_cnt;
reg next_stalled;
reg next_seq_valid;

wire [23:0] step_addr = fsb_next_addr(seq_addr, bl, no_wrap);
wire [4:0] blen = fsb_burst_len(bl);
wire last_word = (blen != 5'h00) ? (word_cnt == blen - 5'h01) : (seq_addr == `FSB_ADDR_MAX);
wire row_cross = (step_addr == seq_addr + 24'h000001) && ((step_addr[3:0] & `FSB_ROW_MASK) == 4'h0);

// stall depth follows the current address offset inside its 4-word group; at a row end that offset is 3, so latency minus one
always @* begin
  case (seq_addr[1:0])
    2'h0: stall_len = 4'h0;
    2'h3: stall_len = lc_eff - 4'h1;
    default: stall_len = ({2'h0, seq_addr[1:0]} < lc_eff) ? {2'h0, seq_addr[1:0]} : lc_eff - 4'h1;
  endcase
end

always @* begin
  next_state = state;
  next_lat_cnt = lat_cnt;
  next_seq_addr = seq_addr;
  next_word_cnt = word_cnt;
  next_stall_cnt = stall_cnt;
  next_stalled = stalled;
  next_seq_valid = seq_valid;
  if (valid_edge && !ce_n_s && !latch_n_s) begin
    next_state = ST_LAT;
    next_lat_cnt = 4'h1;
    next_seq_addr = addr_s;
    next_word_cnt = 5'h00;
    next_seq_valid = 1'b0;
    // aligned starts never stall; nonarray reads skip row-end handling
    next_stalled = (addr_s[3:0] == 4'h0) | nonarray_sel;
  end else if (valid_edge) begin
    case (state)
      ST_LAT: begin
        if (lat_cnt == lc_eff - 4'h1) begin
          next_seq_valid = 1'b1;
          next_state = ST_RUN;
        end else begin
          next_lat_cnt = lat_cnt + 4'h1;
        end
      end
      ST_RUN: begin
        if (last_word) begin
          next_seq_valid = 1'b0;
          next_state = ST_DONE;
        end else begin
          next_word_cnt = word_cnt + 5'h01;
          if (!nonarray_sel) begin
            next_seq_addr = step_addr;
          end
          if (!stalled && row_cross) begin
            next_stalled = 1'b1;
            if (stall_len != 4'h0) begin
              next_seq_valid = 1'b0;
              next_stall_cnt = stall_len;
              next_state = ST_STALL;
            end
          end
        end
      end
      ST_STALL: begin
        if (stall_cnt == 4'h1) begin
          next_seq_valid = 1'b1;
          next_state = ST_RUN;
        end else begin
          next_stall_cnt = stall_cnt - 4'h1;
        end
      end
      ST_DONE: begin
        next_state = ST_DONE;
      end
      default: begin
        next_state = ST_IDLE;
        next_seq_valid = 1'b0;
      end
    endcase
  end
end

always @(posedge clk) begin
  if (rst || !hw_rst_n_s || ce_n_s || !sync_mode) begin
    state <= ST_IDLE;
    lat_cnt <= 4'h0;
    seq_addr <= 24'h000000;
    word_cnt <= 5'h00;
    stall_cnt <= 4'h0;
    stalled <= 1'b0;
    seq_valid <= 1'b0;
  end else begin
    state <= next_state;
    lat_cnt <= next_lat_cnt;
    seq_addr <= next_seq_addr;
    word_cnt <= next_word_cnt;
    stall_cnt <= next_stall_cnt;
    stalled <= next_stalled;
    seq_valid <= next_seq_valid;
  end
end

assign burst_active = (state != ST_IDLE) && (state != ST_DONE);

////////////////////////////////////////////////////////////////////////////////
// array and data pins

wire [15:0] mem_rdata;
wire [7:0] mem_raddr = sync_mode ? next_seq_addr[7:0] : addr_s[7:0];

// reads are at least two clk cycles apart from any burst edge, so the registered read is ready
fsb_word_mem u_mem (
  .clk(clk),
  .wr_en(array_wr),
  .wr_addr(array_wr_addr),
  .wr_data(array_wr_data),
  .rd_addr(mem_raddr),
  .rd_data(mem_rdata)
);

wire [15:0] read_word = nonarray_sel ? nonarray_word : mem_rdata;

always @(posedge clk) begin
  if (rst) begin
    dq_out <= 16'h0000;
    dq_oe <= 1'b0;
  end else begin
    dq_oe <= bus_active;
    if (!sync_mode) begin
      dq_out <= read_word;
    end else if (valid_edge && seq_valid) begin
      dq_out <= read_word;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// wait pin

reg wait_act;

always @(posedge clk) begin
  if (rst || !hw_rst_n_s || !sync_mode) begin
    wait_act <= 1'b0;
  end else if (valid_edge && bus_active) begin
    // early mode looks one edge ahead so wait drops a cycle before the data
    wait_act <= wait_early ? ~next_seq_valid : ~seq_valid;
  end
end

always @(posedge clk) begin
  if (rst) begin
    wait_oe <= 1'b0;
  end else begin
    wait_oe <= bus_active;
  end
end

assign wait_out = wait_pol ? wait_act : ~wait_act;

endmodule

// [design/fsb_word_mem.v]
// small word array with a registered read port
`timescale 1ns/10ps
module fsb_word_mem (
  // clock
  input wire clk,
  // write port
  input wire wr_en,
  input wire [7:0] wr_addr,
  input wire [15:0] wr_data,
  // read port
  input wire [7:0] rd_addr,
  output reg [15:0] rd_data
);

reg [15:0] words [0:255];

always @(posedge clk) begin
  if (wr_en) begin
    words[wr_addr] <= wr_data;
  end
  rd_data <= words[rd_addr];
end

endmodule

// [dv/fsb_ctrl_model.sv]
// memory controller model: drives the flash pins and samples burst data
`timescale 1ns/10ps
module fsb_ctrl_model (
  // clock
  input logic clk,
  // pins towards the flash
  output logic burst_clk,
  output logic address_latch_n,
  output logic chip_sel_n,
  output logic out_en_n,
  output logic [23:0] addr,
  // pins from the flash
  input logic [15:0] dq_out,
  input logic wait_out
);
  logic [15:0] cap_dq [0:15];
  logic cap_wt [0:15];
  initial begin
    burst_clk = 1'b0;
    address_latch_n = 1'b1;
    chip_sel_n = 1'b1;
    out_en_n = 1'b1;
    addr = 24'h0;
  end
  task automatic pins(input logic cs_n, input logic oe_n, input logic [23:0] a);
    chip_sel_n <= cs_n;
    out_en_n <= oe_n;
    addr <= a;
    repeat (12) @(posedge clk);
  endtask
  // half period of four clocks; data and wait are sampled once per period, after the falling edge, so stalls are recorded
  task automatic burst(input logic [23:0] a, input int n);
    address_latch_n <= 1'b0;
    chip_sel_n <= 1'b0;
    out_en_n <= 1'b0;
    addr <= a;
    repeat (8) @(posedge clk);
    for (int k = 0; k < n; k++) begin
      burst_clk <= 1'b1;
      repeat (4) @(posedge clk);
      burst_clk <= 1'b0;
      repeat (4) @(posedge clk);
      cap_dq[k] = dq_out;
      cap_wt[k] = wait_out;
      // latch stays low over the first edge of either polarity
      address_latch_n <= 1'b1;
    end
    // released address shows the inverse so stale values cannot pass
    pins(1'b1, 1'b1, ~a);
  endtask
endmodule

// [dv/fsb_read_ctrl_chk.sv]
// pin-level assertions for the flash burst read control block
`timescale 1ns/10ps
`include "fsb_defines.vh"
module fsb_read_ctrl_chk (
  // clock and reset
  input logic clk,
  input logic rst,
  // controller pins and configuration
  input logic chip_sel_n,
  input logic out_en_n,
  input logic hw_reset_n,
  input logic cfg_wr,
  input logic [15:0] cfg_wdata,
  // outputs under watch
  input logic wait_out,
  input logic wait_oe,
  input logic [15:0] read_config_word
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // eight clocks cover the pin synchronisers and the output flop
  sequence s_deselect; chip_sel_n [*8]; endsequence
  sequence s_oe_off; out_en_n [*8]; endsequence
  sequence s_selected; (!chip_sel_n && !out_en_n) [*8]; endsequence
  sequence s_quiet; (chip_sel_n && hw_reset_n && $stable(read_config_word)) [*8]; endsequence
  sequence s_async; read_config_word[`FSB_RM_BIT] [*8]; endsequence
  property p_float_cs; s_deselect |-> !wait_oe; endproperty
  property p_float_oe; s_oe_off |-> !wait_oe; endproperty
  property p_drive; s_selected |-> wait_oe; endproperty
  property p_async_level; s_async |-> wait_out == !read_config_word[`FSB_WP_BIT]; endproperty
  property p_wait_still; s_quiet |-> $stable(wait_out); endproperty
  property p_hw_default;
    (!hw_reset_n) [*8] |-> read_config_word == `FSB_CFG_RESET && !wait_out;
  endproperty
  property p_cfg_store;
    cfg_wr && hw_reset_n |=> read_config_word == ($past(cfg_wdata) & `FSB_CFG_WMASK);
  endproperty
  property p_linear_only; cfg_wr && cfg_wdata[`FSB_BS_BIT] |=> !read_config_word[`FSB_BS_BIT]; endproperty
  a_float_cs: assert property (p_float_cs) else $error("wait driven while deselected");
  a_float_oe: assert property (p_float_oe) else $error("wait driven with output off");
  a_drive: assert property (p_drive) else $error("wait not driven");
  a_async_level: assert property (p_async_level) else $error("async wait level");
  a_wait_still: assert property (p_wait_still) else $error("wait moved outside bus cycle");
  a_hw_default: assert property (p_hw_default) else $error("hw reset default");
  a_cfg_store: assert property (p_cfg_store) else $error("config store");
  a_linear_only: assert property (p_linear_only) else $error("order bit set");
endmodule
bind fsb_read_ctrl fsb_read_ctrl_chk u_fsb_read_ctrl_chk (.clk, .rst, .chip_sel_n, .out_en_n, .hw_reset_n,
  .cfg_wr, .cfg_wdata, .wait_out, .wait_oe, .read_config_word);

// [dv/fsb_read_ctrl_tb.sv]
// self-checking bench for the flash burst read control block
`timescale 1ns/10ps
`include "fsb_defines.vh"
module fsb_read_ctrl_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hw_reset_n = 1'b1;
  logic cfg_wr = 1'b0;
  logic [15:0] cfg_wdata = 16'h0;
  logic array_wr = 1'b0;
  logic [7:0] array_wr_addr = 8'h0;
  logic [15:0] array_wr_data = 16'h0;
  logic nonarray_sel = 1'b0;
  logic [15:0] nonarray_word = 16'h5a5a;
  logic seen_active = 1'b0;
  wire burst_clk, address_latch_n, chip_sel_n, out_en_n, dq_oe, wait_out, wait_oe, burst_active;
  wire [23:0] addr;
  wire [15:0] dq_out, read_config_word;
  int n_mismatch = 0;
  int comparisons = 0;
  fsb_read_ctrl u_fsb_read_ctrl (.clk(clk), .rst(rst), .burst_clk(burst_clk), .address_latch_n(address_latch_n),
    .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .hw_reset_n(hw_reset_n), .addr(addr), .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata), .nonarray_sel(nonarray_sel), .nonarray_word(nonarray_word), .array_wr(array_wr),
    .array_wr_addr(array_wr_addr), .array_wr_data(array_wr_data), .dq_out(dq_out), .dq_oe(dq_oe),
    .wait_out(wait_out), .wait_oe(wait_oe), .read_config_word(read_config_word), .burst_active(burst_active));
  fsb_ctrl_model u_fsb_ctrl_model (.clk(clk), .burst_clk(burst_clk), .address_latch_n(address_latch_n),
    .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .addr(addr), .dq_out(dq_out), .wait_out(wait_out));
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    if (burst_active) begin
      seen_active <= 1'b1;
    end
  end
  //////////////////////////////////////////////////////////////
  function automatic logic [15:0] dq(input int k);
    return u_fsb_ctrl_model.cap_dq[k];
  endfunction
  function automatic logic [15:0] wt(input int k);
    return {15'h0, u_fsb_ctrl_model.cap_wt[k]};
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic set_cfg(input logic [15:0] v);
    cfg_wdata <= v;
    cfg_wr <= 1'b1;
    @(posedge clk);
    cfg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_async;
    u_fsb_ctrl_model.pins(1'b0, 1'b0, 24'h5);
    chk("async data", 16'ha505, dq_out);
    chk("async wait", 16'h0, {15'h0, wait_out});
    chk("wait driven", 16'h1, {15'h0, wait_oe});
    chk("data driven", 16'h1, {15'h0, dq_oe});
    u_fsb_ctrl_model.pins(1'b0, 1'b1, 24'h5);
    chk("wait float oe", 16'h0, {15'h0, wait_oe});
    chk("data float oe", 16'h0, {15'h0, dq_oe});
    set_cfg(16'h8000);
    u_fsb_ctrl_model.pins(1'b0, 1'b0, 24'h6);
    chk("low polarity idle", 16'h1, {15'h0, wait_out});
    u_fsb_ctrl_model.pins(1'b1, 1'b1, 24'hfffff9);
    chk("wait float cs", 16'h0, {15'h0, wait_oe});
  endtask
  task automatic t_wrap;
    set_cfg(16'h14c1);
    chk("stored config", 16'h1441, read_config_word);
    u_fsb_ctrl_model.burst(24'h2, 7);
    chk("wait before data", 16'h1, wt(1));
    chk("wait at data", 16'h0, wt(2));
    for (int k = 0; k < 4; k++) chk("wrap word", 16'ha500 + 16'((k + 2) % 4), dq(k + 2));
    chk("wait after end", 16'h1, wt(6));
    chk("held word", 16'ha501, dq(6));
    chk("burst active seen", 16'h1, {15'h0, seen_active});
    chk("burst idle", 16'h0, {15'h0, burst_active});
  endtask
  task automatic t_fall;
    set_cfg(16'h1401);
    u_fsb_ctrl_model.burst(24'h0, 7);
    chk("fall wait", 16'h1, wt(2));
    chk("fall wait off", 16'h0, wt(3));
    for (int k = 0; k < 4; k++) chk("fall word", 16'ha500 + 16'(k), dq(k + 3));
  endtask
  task automatic t_nonarray;
    nonarray_sel <= 1'b1;
    set_cfg(16'h1c4f);
    u_fsb_ctrl_model.burst(24'hf, 6);
    chk("nonarray wait", 16'h1, wt(2));
    chk("nonarray word", 16'h5a5a, dq(3));
    chk("nonarray no stall", 16'h0, wt(4));
    chk("nonarray repeat", 16'h5a5a, dq(5));
    nonarray_sel <= 1'b0;
  endtask
  task automatic t_cont_end;
    set_cfg(16'h144f);
    u_fsb_ctrl_model.burst(24'hfffffe, 5);
    chk("end word 0", 16'ha520, dq(2));
    chk("end word 1", 16'ha521, dq(3));
    chk("end wait", 16'h1, wt(4));
    chk("end hold", 16'ha521, dq(4));
  endtask
  task automatic t_linear;
    set_cfg(16'h1449);
    u_fsb_ctrl_model.burst(24'h2, 6);
    for (int k = 0; k < 4; k++) chk("linear word", 16'ha502 + 16'(k), dq(k + 2));
  endtask
  task automatic t_early;
    set_cfg(16'h1541);
    u_fsb_ctrl_model.burst(24'h0, 4);
    chk("early wait latch", 16'h1, wt(0));
    chk("early wait", 16'h0, wt(1));
    chk("early first word", 16'ha500, dq(2));
  endtask
  task automatic t_row;
    set_cfg(16'h1c4f);
    u_fsb_ctrl_model.burst(24'hf, 8);
    chk("row first word", 16'ha50f, dq(3));
    chk("row stall 1", 16'h1, wt(4));
    chk("row stall 2", 16'h1, wt(5));
    chk("row stall hold", 16'ha50f, dq(5));
    chk("row next word", 16'ha510, dq(6));
    chk("row wait off", 16'h0, wt(6));
  endtask
  task automatic t_hwreset;
    hw_reset_n <= 1'b0;
    repeat (12) @(posedge clk);
    chk("hw reset config", `FSB_CFG_RESET, read_config_word);
    chk("hw reset wait", 16'h0, {15'h0, wait_out});
    hw_reset_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    chk("reset config", `FSB_CFG_RESET, read_config_word);
    chk("reset wait oe", 16'h0, {15'h0, wait_oe});
    for (int i = 0; i < 34; i++) begin
      array_wr <= 1'b1;
      array_wr_addr <= 8'(i < 32 ? i : i + 222);
      array_wr_data <= 16'ha500 + 16'(i);
      @(posedge clk);
    end
    array_wr <= 1'b0;
    t_async;
    t_wrap;
    t_linear;
    t_early;
    t_row;
    t_fall;
    t_nonarray;
    t_cont_end;
    t_hwreset;
    tally_and_finish;
  end
  // the whole sequence needs about six hundred clocks
  initial begin
    repeat (8000) @(posedge clk);
    n_mismatch++;
    tally_and_finish;
  end
endmodule
